/* disp_port_pkg.sv */
package disp_port_pkg;
  localparam int CLK_MHZ = 50;
  localparam int DATA_W = 16;
  localparam int CMD_W = 18;
  localparam int CMD_WR_BIT = 17;
  localparam int CMD_RS_BIT = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int SETUP_NS = 20;
  localparam int WR_LOW_NS = 40;
  localparam int RD_LOW_NS = 160;
  localparam int HOLD_NS = 20;
  localparam int RES_LOW_NS = 10000;
  localparam int RES_WAIT_NS = 120000;
  localparam int BL_STEP_NS = 200;
  localparam int I2C_Q_NS = 625;
  localparam int TP_CLOCK = 0;
  localparam int TP_DATA = 1;
  localparam int TP_RESET = 2;
  localparam int TP_INT = 3;
  localparam logic STROBE_OFF = 1'b1;
  localparam logic LINE_FREE = 1'b1;
  localparam logic [15:0] BUS_RST = 16'h0000;

  // least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int SETUP_CYC = ns_to_cyc(SETUP_NS);
  localparam int WR_LOW_CYC = ns_to_cyc(WR_LOW_NS);
  localparam int RD_LOW_CYC = ns_to_cyc(RD_LOW_NS);
  localparam int HOLD_CYC = ns_to_cyc(HOLD_NS);
  localparam int RES_LOW_CYC = ns_to_cyc(RES_LOW_NS);
  localparam int RES_WAIT_CYC = ns_to_cyc(RES_WAIT_NS);
  localparam int BL_STEP_CYC = ns_to_cyc(BL_STEP_NS);
  localparam int I2C_Q_CYC = ns_to_cyc(I2C_Q_NS);

  typedef enum logic [1:0] {
    parallel16_no_touch_variant,
    parallel16_resistive_variant,
    parallel16_capacitive_variant
  } touch_variant_e;

  typedef enum logic [1:0] {
    I2C_OP_START,
    I2C_OP_STOP,
    I2C_OP_WRITE,
    I2C_OP_READ
  } i2c_op_e;
endpackage : disp_port_pkg

/* stream_if.sv */
`timescale 1ns/1ps
interface stream_if #(parameter int W = 18) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : stream_if

/* cmd_fifo.sv */
`timescale 1ns/1ps
module cmd_fifo
  import disp_port_pkg::*;
#(
  parameter int W = CMD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  stream_if.snk wr_s,
  stream_if.src rd_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d, ov_q, ov_d;
  logic [W-1:0] od_q, od_d;
  logic push, pop;

  assign wr_s.ready = rdy_q;
  assign rd_s.valid = ov_q;
  assign rd_s.data = od_q;

  always_comb begin
    push = wr_s.valid && rdy_q;
    pop = (cnt_q != '0) && (!ov_q || rd_s.ready);
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    rdy_d = cnt_d != FULL;
    ov_d = pop ? 1'b1 : (rd_s.ready ? 1'b0 : ov_q);
    od_d = pop ? mem_q[rp_q] : od_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= wr_s.data;
    end
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end

  full_blocks_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cnt_q == FULL) |-> !rdy_q)
    else $error("fifo accepts while full");
endmodule : cmd_fifo

/* backlight_pwm.sv */
`timescale 1ns/1ps
module backlight_pwm
  import disp_port_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [7:0] duty_i,
  output logic pwm_o
);
  logic [7:0] pre_q, pre_d, step_q, step_d, duty_q, duty_d;
  logic en_q, out_d;
  logic tick;

  always_comb begin
    tick = pre_q == 8'(BL_STEP_CYC - 1);
    pre_d = tick ? 8'h00 : pre_q + 8'h01;
    step_d = tick ? step_q + 8'h01 : step_q;
    // duty taken only at period start so no runt pulses
    duty_d = (tick && step_q == 8'hff) ? duty_i : duty_q;
    out_d = en_q && (step_q < duty_q);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pre_q <= 8'h00;
      step_q <= 8'h00;
      duty_q <= 8'h00;
      en_q <= 1'b0;
      pwm_o <= 1'b0;
    end else begin
      pre_q <= pre_d;
      step_q <= step_d;
      duty_q <= duty_d;
      en_q <= en_i;
      pwm_o <= out_d;
    end
  end

  bl_disable_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !en_q |=> !pwm_o)
    else $error("backlight high while disabled");
  bl_zero_duty_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (duty_q == 8'h00) |=> !pwm_o)
    else $error("backlight high at zero duty");
endmodule : backlight_pwm

/* mcu16_display_touch_port.sv */
`timescale 1ns/1ps
// Behaviour
// - read strobe low only during each read transfer
// - write strobe low only during each write transfer
// - register select low for index/status, high for memory/data
// - pulse display reset low, release, then start transfers
// - master reset resets all control state; synchronisers and FIFO storage keep theirs
// - 16-bit two-way data bus, driven on writes, sampled on reads
// - backlight output carries a duty-cycle waveform
// - backlight high enables converter, low disables it
// - no-touch variant: pins are GPIO, one pair optionally third I2C
// - resistive variant: four pins are panel electrodes
// - capacitive variant: I2C master drives clock, drives/samples data
// - capacitive variant: dedicated touch controller reset output
// - capacitive variant: touch interrupt monitored as input
// - block runs from one clock of stated rate
module mcu16_display_touch_port
  import disp_port_pkg::*;
#(
  parameter int RES_WAIT = RES_WAIT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] touch_variant_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic cmd_rs_i,
  input wire logic [15:0] cmd_data_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic display_ready_o,
  output logic display_read_strobe_n_o,
  output logic display_write_strobe_n_o,
  output logic display_register_select_o,
  output logic display_reset_out_n_o,
  input wire logic [15:0] disp_bus_i,
  output logic [15:0] disp_bus_o,
  output logic disp_bus_oe_n_o,
  input wire logic bl_enable_i,
  input wire logic [7:0] bl_duty_i,
  output logic backlight_o,
  input wire logic [3:0] tp_i,
  output logic [3:0] tp_o,
  output logic [3:0] tp_oe_n_o,
  input wire logic [3:0] pin_out_i,
  input wire logic [3:0] pin_dir_i,
  output logic [3:0] pin_in_o,
  input wire logic third_i2c_en_i,
  input wire logic touch_reset_n_i,
  output logic touch_int_o,
  input wire logic i2c_cmd_valid_i,
  input wire logic [1:0] i2c_cmd_i,
  input wire logic [7:0] i2c_wdata_i,
  input wire logic i2c_rd_nack_i,
  output logic i2c_busy_o,
  output logic i2c_done_o,
  output logic [7:0] i2c_rdata_o,
  output logic i2c_nack_o
);
  typedef enum logic [2:0] {
    D_RES_LOW, D_RES_WAIT, D_IDLE, D_SETUP, D_STROBE, D_HOLD
  } disp_st_e;
  typedef enum logic [1:0] {I_IDLE, I_START, I_STOP, I_BYTE} i2c_st_e;

  stream_if #(.W(CMD_W)) in_s ();
  stream_if #(.W(CMD_W)) out_s ();

  logic [15:0] bus_meta_q, bus_sync_q;
  logic [3:0] tp_meta_q, tp_sync_q;
  touch_variant_e var_q, var_d;
  logic cap, i2c_on;

  assign in_s.valid = cmd_valid_i;
  assign in_s.data = {cmd_write_i, cmd_rs_i, cmd_data_i};
  assign cmd_ready_o = in_s.ready;

  cmd_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_s(in_s),
    .rd_s(out_s)
  );

  backlight_pwm u_bl (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .en_i(bl_enable_i),
    .duty_i(bl_duty_i),
    .pwm_o(backlight_o)
  );

  // variant held from reset, checked later, out of range means no touch
  always_comb begin
    var_d = var_q;
    if (rst_i) begin
      unique case (touch_variant_i)
        2'h1: var_d = parallel16_resistive_variant;
        2'h2: var_d = parallel16_capacitive_variant;
        default: var_d = parallel16_no_touch_variant;
      endcase
    end
    cap = var_q == parallel16_capacitive_variant;
    i2c_on = cap || (var_q == parallel16_no_touch_variant && third_i2c_en_i);
  end

  // pins cross in through two flops; all logic reads the second only
  always_ff @(posedge ref_clk_i) begin
    var_q <= var_d;
    bus_meta_q <= disp_bus_i;
    bus_sync_q <= bus_meta_q;
    tp_meta_q <= tp_i;
    tp_sync_q <= tp_meta_q;
  end

  // display transfer engine
  disp_st_e dst_q, dst_d;
  logic [19:0] dcnt_q, dcnt_d;
  logic cur_wr_q, cur_wr_d;
  logic rd_n_d, wr_n_d, rs_d, res_n_d, oe_n_d, rdv_d, rdy_d;
  logic [15:0] bus_d, rdat_d;

  assign out_s.ready = dst_q == D_IDLE;

  always_comb begin
    dst_d = dst_q;
    dcnt_d = (dcnt_q != '0) ? dcnt_q - 20'h1 : dcnt_q;
    cur_wr_d = cur_wr_q;
    rd_n_d = display_read_strobe_n_o;
    wr_n_d = display_write_strobe_n_o;
    rs_d = display_register_select_o;
    res_n_d = display_reset_out_n_o;
    oe_n_d = disp_bus_oe_n_o;
    bus_d = disp_bus_o;
    rdat_d = rd_data_o;
    rdv_d = 1'b0;
    unique case (dst_q)
      D_RES_LOW: begin
        if (dcnt_q == '0) begin
          res_n_d = 1'b1;
          dst_d = D_RES_WAIT;
          dcnt_d = 20'(RES_WAIT - 1);
        end
      end
      D_RES_WAIT: begin
        if (dcnt_q == '0) begin
          dst_d = D_IDLE;
        end
      end
      D_IDLE: begin
        if (out_s.valid) begin
          cur_wr_d = out_s.data[CMD_WR_BIT];
          rs_d = out_s.data[CMD_RS_BIT];
          bus_d = out_s.data[15:0];
          oe_n_d = !out_s.data[CMD_WR_BIT];
          dst_d = D_SETUP;
          dcnt_d = 20'(SETUP_CYC - 1);
        end
      end
      D_SETUP: begin
        if (dcnt_q == '0) begin
          rd_n_d = cur_wr_q;
          wr_n_d = !cur_wr_q;
          dst_d = D_STROBE;
          dcnt_d = cur_wr_q ? 20'(WR_LOW_CYC - 1) : 20'(RD_LOW_CYC - 1);
        end
      end
      D_STROBE: begin
        if (dcnt_q == '0) begin
          rd_n_d = STROBE_OFF;
          wr_n_d = STROBE_OFF;
          if (!cur_wr_q) begin
            rdat_d = bus_sync_q;
            rdv_d = 1'b1;
          end
          dst_d = D_HOLD;
          dcnt_d = 20'(HOLD_CYC - 1);
        end
      end
      D_HOLD: begin
        if (dcnt_q == '0) begin
          oe_n_d = 1'b1;
          dst_d = D_IDLE;
        end
      end
    endcase
    rdy_d = dst_d != D_RES_LOW && dst_d != D_RES_WAIT;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dst_q <= D_RES_LOW;
      dcnt_q <= 20'(RES_LOW_CYC - 1);
      cur_wr_q <= 1'b0;
      display_read_strobe_n_o <= STROBE_OFF;
      display_write_strobe_n_o <= STROBE_OFF;
      display_register_select_o <= 1'b0;
      display_reset_out_n_o <= 1'b0;
      disp_bus_oe_n_o <= 1'b1;
      disp_bus_o <= BUS_RST;
      rd_data_o <= BUS_RST;
      rd_valid_o <= 1'b0;
      display_ready_o <= 1'b0;
    end else begin
      dst_q <= dst_d;
      dcnt_q <= dcnt_d;
      cur_wr_q <= cur_wr_d;
      display_read_strobe_n_o <= rd_n_d;
      display_write_strobe_n_o <= wr_n_d;
      display_register_select_o <= rs_d;
      display_reset_out_n_o <= res_n_d;
      disp_bus_oe_n_o <= oe_n_d;
      disp_bus_o <= bus_d;
      rd_data_o <= rdat_d;
      rd_valid_o <= rdv_d;
      display_ready_o <= rdy_d;
    end
  end

  // i2c bit engine, quarter-period steps, open-drain lines
  i2c_st_e ist_q, ist_d;
  logic [5:0] qc_q, qc_d;
  logic [1:0] qt_q, qt_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, sh_n;
  logic scl_q, scl_d, sda_q, sda_d, rd_q, rd_d, ack_q, ack_d;
  logic nack_d, done_d, busy_d;
  logic [7:0] irdat_d;
  logic tick;
  logic sda_in;

  always_comb begin
    sda_in = tp_sync_q[TP_DATA];
    tick = qc_q == 6'(I2C_Q_CYC - 1);
    ist_d = ist_q;
    qc_d = (ist_q == I_IDLE || tick) ? 6'h00 : qc_q + 6'h01;
    qt_d = qt_q;
    bit_d = bit_q;
    sh_d = sh_q;
    sh_n = rd_q ? sh_q : {sh_q[6:0], 1'b0};
    scl_d = scl_q;
    sda_d = sda_q;
    rd_d = rd_q;
    ack_d = ack_q;
    nack_d = i2c_nack_o;
    irdat_d = i2c_rdata_o;
    done_d = 1'b0;
    if (ist_q == I_IDLE) begin
      if (i2c_cmd_valid_i && i2c_on) begin
        qt_d = 2'h0;
        bit_d = 4'h0;
        unique case (i2c_op_e'(i2c_cmd_i))
          I2C_OP_START: begin
            ist_d = I_START;
            sda_d = LINE_FREE;
          end
          I2C_OP_STOP: begin
            ist_d = I_STOP;
            sda_d = 1'b0;
          end
          I2C_OP_WRITE: begin
            ist_d = I_BYTE;
            rd_d = 1'b0;
            sh_d = i2c_wdata_i;
            sda_d = i2c_wdata_i[7];
          end
          I2C_OP_READ: begin
            ist_d = I_BYTE;
            rd_d = 1'b1;
            ack_d = i2c_rd_nack_i;
            sh_d = 8'h00;
            sda_d = LINE_FREE;
          end
        endcase
      end
    end else if (tick) begin
      qt_d = qt_q + 2'h1;
      unique case (ist_q)
        I_START: begin
          if (qt_q == 2'h0) scl_d = 1'b1;
          if (qt_q == 2'h1) sda_d = 1'b0;
          if (qt_q == 2'h2) scl_d = 1'b0;
          if (qt_q == 2'h3) ist_d = I_IDLE;
        end
        I_STOP: begin
          if (qt_q == 2'h0) scl_d = 1'b1;
          if (qt_q == 2'h1) sda_d = LINE_FREE;
          if (qt_q == 2'h3) ist_d = I_IDLE;
        end
        default: begin
          if (qt_q == 2'h0) scl_d = 1'b1;
          if (qt_q == 2'h1) begin
            if (bit_q != 4'h8 && rd_q) sh_d = {sh_q[6:0], sda_in};
            if (bit_q == 4'h8 && !rd_q) nack_d = sda_in;
          end
          if (qt_q == 2'h2) scl_d = 1'b0;
          if (qt_q == 2'h3) begin
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h8) begin
              ist_d = I_IDLE;
              sda_d = 1'b0;
              if (rd_q) irdat_d = sh_q;
            end else begin
              sh_d = sh_n;
              if (bit_q == 4'h7) sda_d = rd_q ? ack_q : LINE_FREE;
              else sda_d = rd_q ? LINE_FREE : sh_n[7];
            end
          end
        end
      endcase
      done_d = ist_d == I_IDLE;
    end
    busy_d = ist_d != I_IDLE;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ist_q <= I_IDLE;
      qc_q <= 6'h00;
      qt_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      scl_q <= LINE_FREE;
      sda_q <= LINE_FREE;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      i2c_nack_o <= 1'b0;
      i2c_rdata_o <= 8'h00;
      i2c_done_o <= 1'b0;
      i2c_busy_o <= 1'b0;
    end else begin
      ist_q <= ist_d;
      qc_q <= qc_d;
      qt_q <= qt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
      i2c_nack_o <= nack_d;
      i2c_rdata_o <= irdat_d;
      i2c_done_o <= done_d;
      i2c_busy_o <= busy_d;
    end
  end

  // touch pin routing per variant
  logic [3:0] tpo_d, tpe_d;
  logic tint_d;

  always_comb begin
    tpo_d = pin_out_i;
    tpe_d = ~pin_dir_i;
    if (i2c_on) begin
      tpo_d[TP_CLOCK] = 1'b0;
      tpe_d[TP_CLOCK] = scl_q;
      tpo_d[TP_DATA] = 1'b0;
      tpe_d[TP_DATA] = sda_q;
    end
    if (cap) begin
      tpo_d[TP_RESET] = touch_reset_n_i;
      tpe_d[TP_RESET] = 1'b0;
      tpo_d[TP_INT] = 1'b0;
      tpe_d[TP_INT] = 1'b1;
    end
    tint_d = cap && !tp_sync_q[TP_INT];
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tp_o <= 4'h0;
      tp_oe_n_o <= 4'hf;
      pin_in_o <= 4'h0;
      touch_int_o <= 1'b0;
    end else begin
      tp_o <= tpo_d;
      tp_oe_n_o <= tpe_d;
      pin_in_o <= tp_sync_q;
      touch_int_o <= tint_d;
    end
  end

  strobe_excl_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(!display_read_strobe_n_o && !display_write_strobe_n_o))
    else $error("read and write strobes low together");
  wr_stable_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !display_write_strobe_n_o && $past(!display_write_strobe_n_o)
    |-> $stable(disp_bus_o) && $stable(display_register_select_o))
    else $error("data or select moved during write strobe");
  wr_width_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(display_write_strobe_n_o) |->
    (!display_write_strobe_n_o && !disp_bus_oe_n_o)[*2] ##1 display_write_strobe_n_o)
    else $error("write strobe width wrong");
  rd_width_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(display_read_strobe_n_o) |->
    (!display_read_strobe_n_o)[*8] ##1 (display_read_strobe_n_o && rd_valid_o))
    else $error("read strobe width or capture wrong");
  rd_release_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !display_read_strobe_n_o |-> disp_bus_oe_n_o)
    else $error("bus driven while reading");
  res_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !display_reset_out_n_o |-> display_read_strobe_n_o &&
    display_write_strobe_n_o && !display_ready_o)
    else $error("transfer during display reset");
  i2c_od_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cap |=> tp_o[TP_CLOCK] == 1'b0 && tp_o[TP_DATA] == 1'b0)
    else $error("i2c line driven high");
  treset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cap |=> !tp_oe_n_o[TP_RESET] && tp_o[TP_RESET] == $past(touch_reset_n_i))
    else $error("touch reset not driven");
  tint_in_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cap |=> tp_oe_n_o[TP_INT] && touch_int_o == !$past(tp_sync_q[TP_INT]))
    else $error("touch interrupt not monitored");
  gpio_dir_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !i2c_on && !cap |=> tp_oe_n_o == ~$past(pin_dir_i))
    else $error("gpio direction wrong");
endmodule : mcu16_display_touch_port

/* disp_model.sv */
`timescale 1ns/1ps
module disp_model (
  input wire logic clk_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic rs_i,
  input wire logic [15:0] bus_i,
  output logic [15:0] data_o,
  output logic [15:0] wr_cnt_o
);
  logic [15:0] mem [0:63];
  logic [15:0] idx;
  logic [15:0] last;
  logic wr_q;
  logic rd_q;
  initial begin
    idx = 16'h0000;
    last = 16'h0000;
    wr_cnt_o = 16'h0000;
  end
  // released bus shows the inverse of the last driven word
  assign data_o = rd_n_i ? ~last : (rs_i ? mem[idx[5:0]] : idx);
  always @(posedge clk_i) begin
    wr_q <= wr_n_i;
    rd_q <= rd_n_i;
    if (!rd_n_i) begin
      last <= data_o;
    end
    if (wr_n_i && !wr_q) begin
      wr_cnt_o <= wr_cnt_o + 16'h0001;
      if (!rs_i) begin
        idx <= bus_i;
      end else begin
        mem[idx[5:0]] <= bus_i;
        idx <= idx + 16'h0001;
      end
    end
    if (rd_n_i && !rd_q && rs_i) begin
      idx <= idx + 16'h0001;
    end
  end
endmodule : disp_model

/* mcu16_display_touch_port_tb.sv */
`timescale 1ns/1ps
module mcu16_display_touch_port_tb;
  import disp_port_pkg::*;
  localparam int RW = 20;
  logic ref_clk_i = 1'b0, rst_i = 1'b1;
  logic [1:0] variant = 2'h0, i2c_op = 2'h0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_rs = 1'b0, bl_en = 1'b0;
  logic [15:0] cmd_data = 16'h0000;
  logic [7:0] bl_duty = 8'h00, i2c_wd = 8'h00, rdata;
  logic [3:0] pin_out = 4'h0, pin_dir = 4'h0, tb_pin = 4'hf;
  logic i2c_en = 1'b0, trst_n = 1'b1, i2c_v = 1'b0, i2c_nk = 1'b1;
  logic cmd_ready, rd_valid, disp_rdy, rd_n, wr_n, rs, res_n, oe_n, bl, tint, busy, done, nack;
  logic [15:0] rd_data, bus_o, bus_lvl, mdl_data, mdl_wr;
  logic [3:0] tp_o, tp_oe_n, tp_lvl, pin_in;
  logic wr_q, rd_q, rs_q;
  logic [15:0] bus_q;
  logic [8:0] sh = 9'h000;
  int error_cnt = 0, checks_done = 0, cyc = 0, wl = 0, rl = 0;

  assign bus_lvl = !oe_n ? bus_o : mdl_data;
  assign tp_lvl = (~tp_oe_n & tp_o) | (tp_oe_n & tb_pin);

  mcu16_display_touch_port #(.RES_WAIT(RW)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .touch_variant_i(variant), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_write_i(cmd_write), .cmd_rs_i(cmd_rs), .cmd_data_i(cmd_data), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .display_ready_o(disp_rdy), .display_read_strobe_n_o(rd_n),
    .display_write_strobe_n_o(wr_n), .display_register_select_o(rs),
    .display_reset_out_n_o(res_n), .disp_bus_i(bus_lvl), .disp_bus_o(bus_o),
    .disp_bus_oe_n_o(oe_n), .bl_enable_i(bl_en), .bl_duty_i(bl_duty), .backlight_o(bl),
    .tp_i(tp_lvl), .tp_o(tp_o), .tp_oe_n_o(tp_oe_n), .pin_out_i(pin_out), .pin_dir_i(pin_dir),
    .pin_in_o(pin_in), .third_i2c_en_i(i2c_en), .touch_reset_n_i(trst_n), .touch_int_o(tint),
    .i2c_cmd_valid_i(i2c_v), .i2c_cmd_i(i2c_op), .i2c_wdata_i(i2c_wd),
    .i2c_rd_nack_i(i2c_nk), .i2c_busy_o(busy), .i2c_done_o(done), .i2c_rdata_o(rdata),
    .i2c_nack_o(nack));

  disp_model i_disp (.clk_i(ref_clk_i), .rd_n_i(rd_n), .wr_n_i(wr_n), .rs_i(rs),
    .bus_i(bus_lvl), .data_o(mdl_data), .wr_cnt_o(mdl_wr));

  always #10 ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      $display("[ERR] %0t run timed out", $time);
      complete_run();
    end
  end

  // strobe monitor: overlap, bus release, held qualifiers, pulse widths
  always @(posedge ref_clk_i) begin
    if (!rst_i) begin
      if (!rd_n || !wr_n) chk(16'(!rd_n && !wr_n), 16'h0000, "strobe overlap");
      if (!rd_n) chk(16'(oe_n), 16'h0001, "bus driven in read");
      if (!wr_n && !wr_q) chk(16'(rs !== rs_q || bus_o !== bus_q), 16'h0000, "moved");
      if (wr_n && !wr_q) chk(16'(wl), 16'(WR_LOW_CYC), "write pulse");
      if (rd_n && !rd_q) chk(16'(rl), 16'(RD_LOW_CYC), "read pulse");
    end
    wl <= wr_n ? 0 : wl + 1;
    rl <= rd_n ? 0 : rl + 1;
    wr_q <= wr_n;
    rd_q <= rd_n;
    rs_q <= rs;
    bus_q <= bus_o;
  end

  // bits seen on the touch data line at each clock rise
  always @(posedge tp_lvl[0]) begin
    if (busy === 1'b1) sh <= {sh[7:0], tp_lvl[1]};
  end

  task automatic push(input logic w, input logic r, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_rs <= r;
    cmd_data <= d;
    do @(posedge ref_clk_i); while (cmd_ready !== 1'b1 && ++n < 2000);
    cmd_valid <= 1'b0;
  endtask : push

  task automatic rd_word(input logic r, output logic [15:0] d);
    int n;
    push(1'b0, r, 16'h0000);
    n = 0;
    while (rd_valid !== 1'b1 && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    d = rd_data;
  endtask : rd_word

  task automatic do_reset(input logic [1:0] v);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    variant <= v;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask : do_reset

  task automatic t_start();
    int acc, lo, n;
    logic early;
    logic [15:0] d;
    acc = 0;
    lo = 0;
    early = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk({12'h000, rd_n, wr_n, oe_n, res_n}, 16'h000e, "in reset");
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge ref_clk_i);
      if (res_n === 1'b0) lo++;
      if (cmd_ready === 1'b1) begin
        acc++;
        cmd_rs <= 1'b1;
        cmd_data <= 16'h1000 + 16'(acc);
      end
    end
    cmd_valid <= 1'b0;
    chk(16'(acc >= FIFO_DEPTH && acc <= FIFO_DEPTH + 1), 16'h0001, "fifo full");
    while (res_n !== 1'b1 && lo < 2000) begin
      @(posedge ref_clk_i);
      lo++;
      early = early | !wr_n | !rd_n;
    end
    chk(16'(lo >= RES_LOW_CYC && lo <= RES_LOW_CYC + 1), 16'h0001, "reset pulse");
    chk(16'(early | disp_rdy), 16'h0000, "early transfer");
    n = 0;
    while (mdl_wr !== 16'(acc) && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(mdl_wr, 16'(acc), "writes drained");
    chk(16'(disp_rdy), 16'h0001, "display ready");
    push(1'b1, 1'b0, 16'h0000);
    for (n = 1; n <= 4; n++) begin
      rd_word(1'b1, d);
      chk(d, 16'h1000 + 16'(n), "stored word");
    end
    $display("test start done");
  endtask : t_start

  task automatic t_rw();
    logic [15:0] d;
    push(1'b1, 1'b0, 16'h0028);
    push(1'b1, 1'b1, 16'ha5c3);
    push(1'b1, 1'b1, 16'h5a3c);
    push(1'b1, 1'b0, 16'h0028);
    rd_word(1'b1, d);
    chk(d, 16'ha5c3, "word a");
    rd_word(1'b1, d);
    chk(d, 16'h5a3c, "word b");
    rd_word(1'b0, d);
    chk(d, 16'h002a, "status");
    $display("test rw done");
  endtask : t_rw

  task automatic t_bl(input logic [7:0] duty);
    int hi;
    hi = 0;
    @(posedge ref_clk_i);
    bl_en <= 1'b1;
    bl_duty <= duty;
    repeat (2 * 2560 + 20) @(posedge ref_clk_i);
    repeat (2560) begin
      @(posedge ref_clk_i);
      hi += int'(bl === 1'b1);
    end
    chk(16'(hi), 16'(duty) * 16'(BL_STEP_CYC), "duty");
    bl_en <= 1'b0;
    hi = 0;
    repeat (3) @(posedge ref_clk_i);
    repeat (300) begin
      @(posedge ref_clk_i);
      hi += int'(bl !== 1'b0);
    end
    chk(16'(hi), 16'h0000, "off");
    $display("test backlight done");
  endtask : t_bl

  task automatic i2c_do(input logic [1:0] op, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    i2c_v <= 1'b1;
    i2c_op <= op;
    i2c_wd <= d;
    @(posedge ref_clk_i);
    i2c_v <= 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(16'(n < 2000), 16'h0001, "i2c done");
  endtask : i2c_do

  task automatic t_touch();
    do_reset(2'h0);
    pin_dir <= 4'hf;
    pin_out <= 4'ha;
    repeat (4) @(posedge ref_clk_i);
    chk({8'h00, tp_oe_n, tp_o}, 16'h000a, "gpio out");
    pin_dir <= 4'h0;
    tb_pin <= 4'h6;
    repeat (5) @(posedge ref_clk_i);
    chk({8'h00, tp_oe_n, pin_in}, 16'h00f6, "gpio in");
    tb_pin <= 4'hf;
    i2c_en <= 1'b1;
    i2c_nk <= 1'b0;
    i2c_do(2'(I2C_OP_START), 8'h00);
    sh <= 9'h000;
    i2c_do(2'(I2C_OP_READ), 8'h00);
    chk({8'h00, rdata}, 16'h00ff, "read byte");
    chk({7'h00, sh}, 16'h01fe, "read and ack");
    i2c_en <= 1'b0;
    do_reset(2'h1);
    pin_dir <= 4'h3;
    pin_out <= 4'h1;
    i2c_v <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    i2c_v <= 1'b0;
    chk({8'h00, tp_oe_n, 2'b00, tp_o[1:0]}, 16'h00c1, "electrodes");
    chk(16'(busy), 16'h0000, "i2c off");
    do_reset(2'h2);
    trst_n <= 1'b0;
    tb_pin[3] <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk({14'h0000, tp_oe_n[2], tp_lvl[2]}, 16'h0000, "touch reset");
    chk(16'(tint), 16'h0001, "touch int");
    trst_n <= 1'b1;
    tb_pin[3] <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk({14'h0000, tp_lvl[2], tint}, 16'h0002, "touch idle");
    i2c_do(2'(I2C_OP_START), 8'h00);
    sh <= 9'h000;
    i2c_do(2'(I2C_OP_WRITE), 8'ha6);
    chk({7'h00, sh}, 16'h014d, "byte and ack");
    chk(16'(nack), 16'h0001, "no ack");
    i2c_do(2'(I2C_OP_STOP), 8'h00);
    $display("test touch done");
  endtask : t_touch

  initial begin
    t_start();
    t_rw();
    t_bl(8'h00);
    t_bl(8'hc0);
    t_touch();
    complete_run();
  end
endmodule : mcu16_display_touch_port_tb
